// ### hbcs_consts.vh
// Purpose: Shared constants for the host bus command sequencer.
// Assumes: Included by bare name from the design files.
// Notes:   Microinstruction is {control word[15:0], opcode[2:0], target[5:0]}.
`ifndef HBCS_CONSTS_VH
`define HBCS_CONSTS_VH

// ****************************************************************
// Microinstruction layout
// ****************************************************************
`define HBCS_IW          25
`define HBCS_AW          6
`define HBCS_CW          16
`define HBCS_F_WORD_HI   24
`define HBCS_F_WORD_LO   9
`define HBCS_F_OP_HI     8
`define HBCS_F_OP_LO     6
`define HBCS_F_TGT_HI    5
`define HBCS_F_TGT_LO    0

// ****************************************************************
// Control word bit positions, most significant first
// ****************************************************************
`define HBCS_B_READY     15
`define HBCS_B_INIT_N    14
`define HBCS_B_MAPWR_N   13
`define HBCS_B_CS_CLK    12
`define HBCS_B_OC_CLK    11
`define HBCS_B_DP_CLK    10
`define HBCS_B_MODE      9
`define HBCS_B_SISEL     8
`define HBCS_B_CORE_N    7
`define HBCS_B_HOST_N    6
`define HBCS_B_RDBK_N    5
`define HBCS_B_MEM_N     4

// ****************************************************************
// Sequencer opcodes
// ****************************************************************
`define HBCS_OP_CONT     3'h0
`define HBCS_OP_GOTO     3'h1
`define HBCS_OP_MWCMD    3'h2
`define HBCS_OP_MWMOD    3'h3
`define HBCS_OP_WAITSEL  3'h4
`define HBCS_OP_BRNWR    3'h5

// ****************************************************************
// Microcode addresses
// ****************************************************************
`define HBCS_A_RESET     6'h3F
`define HBCS_A_IDLE      6'h20
`define HBCS_A_MEM       6'h00
`define HBCS_A_MEM2      6'h01
`define HBCS_A_SSR_RD    6'h03
`define HBCS_A_SSRP      6'h08
`define HBCS_A_SSR_WR    6'h09
`define HBCS_A_CMD_LO    6'h10
`define HBCS_A_CMD_HI    6'h18

// ****************************************************************
// Clock command codes
// ****************************************************************
`define HBCS_CK_NOP      4'h0
`define HBCS_CK_HALT1    4'h1
`define HBCS_CK_HALT     4'h2
`define HBCS_CK_RUN      4'h3
`define HBCS_CK_STEP     4'h4
`define HBCS_CK_LDPIPE   4'h5
`define HBCS_CK_STEPCTL  4'h6
`define HBCS_CK_LDOPC    4'h7
`define HBCS_CK_STEPDAT  4'h8
`define HBCS_CK_STEPRST  4'h9
`define HBCS_CK_SEMA     4'hA

// ****************************************************************
// Control word patterns
// ****************************************************************
`define HBCS_W_RESET     16'h60F2
`define HBCS_W_IDLE      16'h6070
`define HBCS_W_DONE      16'hE070
`define HBCS_W_MEM       16'h60A1
`define HBCS_W_MEM2      16'hE0A1
`define HBCS_W_SSRP      16'h62B1
`define HBCS_W_SSR_WR    16'hE6B1
`define HBCS_W_SSR_RD    16'hE691

// ****************************************************************
// AXI4-Lite register map
// ****************************************************************
`define HBCS_ADDR_W      4
`define HBCS_REG_CTRL    4'h0
`define HBCS_REG_STATUS  4'h4
`define HBCS_REG_CWORD   4'h8
`define HBCS_RESP_OKAY   2'h0
`define HBCS_RESP_SLVERR 2'h2

`endif

// ### hbcs_ucode_rom.v
// Purpose: Microcode store for the host bus command sequencer.
// Assumes: One read per clock; the word appears from a register.
// Notes:   A load request fetches the reset location in place of the address.
`include "hbcs_consts.vh"

module hbcs_ucode_rom
(
  input  wire                    clk_i,
  input  wire                    load_reset_i,
  input  wire [`HBCS_AW-1:0]     addr_i,
  output reg  [`HBCS_IW-1:0]     data_o
);

  // ****************************************************************
  // Table lookup
  // ****************************************************************
  reg [`HBCS_IW-1:0] word_nxt;
  reg [`HBCS_AW-1:0] sel;

  // Decodes the fetch address into a stored microinstruction.
  always @*
  begin
    sel = load_reset_i ? `HBCS_A_RESET : addr_i;
    case (sel)
      6'h3F:                      word_nxt = {`HBCS_W_RESET, `HBCS_OP_GOTO, `HBCS_A_IDLE};
      6'h20, 6'h28, 6'h30, 6'h38: word_nxt = {`HBCS_W_IDLE, `HBCS_OP_MWCMD, 6'h00};
      6'h00:                      word_nxt = {`HBCS_W_MEM, `HBCS_OP_CONT, 6'h00};
      6'h01:                      word_nxt = {`HBCS_W_MEM2, `HBCS_OP_WAITSEL, `HBCS_A_IDLE};
      6'h08:                      word_nxt = {`HBCS_W_SSRP, `HBCS_OP_BRNWR, `HBCS_A_SSR_RD};
      6'h09:                      word_nxt = {`HBCS_W_SSR_WR, `HBCS_OP_WAITSEL, `HBCS_A_IDLE};
      6'h03:                      word_nxt = {`HBCS_W_SSR_RD, `HBCS_OP_WAITSEL, `HBCS_A_IDLE};
      6'h10, 6'h18:               word_nxt = {`HBCS_W_IDLE, `HBCS_OP_MWMOD, 6'h00};
      6'h11: word_nxt = {`HBCS_W_DONE | {12'h000, `HBCS_CK_HALT},    `HBCS_OP_WAITSEL, `HBCS_A_IDLE};
      6'h12: word_nxt = {`HBCS_W_DONE | {12'h000, `HBCS_CK_RUN},     `HBCS_OP_WAITSEL, `HBCS_A_IDLE};
      6'h13: word_nxt = {`HBCS_W_DONE | {12'h000, `HBCS_CK_STEP},    `HBCS_OP_WAITSEL, `HBCS_A_IDLE};
      6'h14: word_nxt = {`HBCS_W_DONE | {12'h000, `HBCS_CK_LDPIPE},  `HBCS_OP_WAITSEL, `HBCS_A_IDLE};
      6'h15: word_nxt = {`HBCS_W_DONE | {12'h000, `HBCS_CK_STEPCTL}, `HBCS_OP_WAITSEL, `HBCS_A_IDLE};
      6'h16: word_nxt = {`HBCS_W_DONE | {12'h000, `HBCS_CK_LDOPC},   `HBCS_OP_WAITSEL, `HBCS_A_IDLE};
      6'h17: word_nxt = {`HBCS_W_DONE | {12'h000, `HBCS_CK_STEPDAT}, `HBCS_OP_WAITSEL, `HBCS_A_IDLE};
      6'h19: word_nxt = {`HBCS_W_DONE | {12'h000, `HBCS_CK_STEPRST}, `HBCS_OP_WAITSEL, `HBCS_A_IDLE};
      6'h1A: word_nxt = {`HBCS_W_DONE | {12'h000, `HBCS_CK_SEMA},    `HBCS_OP_WAITSEL, `HBCS_A_IDLE};
      6'h1B: word_nxt = {`HBCS_W_DONE | {12'h000, `HBCS_CK_HALT1},   `HBCS_OP_WAITSEL, `HBCS_A_IDLE};
      6'h1C, 6'h1D, 6'h1E, 6'h1F:
             word_nxt = {`HBCS_W_DONE, `HBCS_OP_WAITSEL, `HBCS_A_IDLE};
      default: word_nxt = {`HBCS_W_IDLE, `HBCS_OP_GOTO, `HBCS_A_IDLE};
    endcase
  end

  // Registers the fetched word so every output changes on a clock edge.
  always @(posedge clk_i)
  begin
    data_o <= word_nxt;
  end

endmodule

// ### hbcs_sequencer.v
// Purpose: Host bus command sequencer with an AXI4-Lite status port.
// Assumes: Host pins are asynchronous and pass two flip-flops first.
// Notes:   One microinstruction per cycle; outputs come from the store register.
`include "hbcs_consts.vh"

// Operation
// - Ready output stays low by default, stalling the host.
// - Ready rises only in the last instruction of a command routine.
// - Init word strobe idles high, low only for initialization word access; every microinstruction holds it high.
// - Opcode map write idles high, pulses low with control store writes; every microinstruction holds it high.
// - Control store shift clock idles low, pulses to shift its chain; no microinstruction pulses it.
// - Opcode chain shift clock idles low, pulses to shift its chain; no microinstruction pulses it.
// - Diagnostic port shift clock idles low, pulses to shift port register.
// - Shadow mode output idles low and selects shadow register mode.
// - Serial input select idles low.
// - Core buffer enable low unless the host owns the bus or reset is active.
// - Host buffer enable idles high, low when coupling host to memory.
// - Readback enable idles high, low to drive port data.
// - Memory enable idles high, low only during memory accesses.
// - Clock command codes 0 to 4: nop, halt once, halt, run, step.
// - Codes 5 to 10 load or step sections, reset step, semaphore; rest reserved.
// - One microinstruction per cycle drives all outputs.
// - Idle waits for selection, then branches to four modes.
// - First dispatch ignores address bits 2 to 0.
// - Memory, port start at once; others branch on bits 2 to 0.
// - Condition flag cleared by reset, never set.
// - Reset forces the program counter to location 63.
// - Reset holds ready low, halts clocks, jumps to idle.
// - First dispatch address is select, address 17, address 16.
// - After ready, hold outputs until deselect, then return to idle.
module hbcs_sequencer
(
  input  wire                      clk_i,
  input  wire                      rst_b_i,
  // Host bus pins.
  input  wire                      board_addressed_n_i,
  input  wire                      host_write_n_i,
  input  wire                      host_addr17_i,
  input  wire                      host_addr16_i,
  input  wire [2:0]                host_addr_lo_i,
  // Control word outputs.
  output wire                      ready_o,
  output wire                      init_word_strobe_n_o,
  output wire                      opmap_write_n_o,
  output wire                      ctrl_store_shift_clk_o,
  output wire                      opcode_chain_shift_clk_o,
  output wire                      diag_port_shift_clk_o,
  output wire                      shadow_mode_o,
  output wire                      serial_in_select_o,
  output wire                      core_buffer_en_n_o,
  output wire                      host_buffer_en_n_o,
  output wire                      diag_readback_en_n_o,
  output wire                      memory_en_n_o,
  output wire [3:0]                clock_command_o,
  // AXI4-Lite slave.
  input  wire [`HBCS_ADDR_W-1:0]   s_axi_awaddr,
  input  wire                      s_axi_awvalid,
  output reg                       s_axi_awready,
  input  wire [31:0]               s_axi_wdata,
  input  wire [3:0]                s_axi_wstrb,
  input  wire                      s_axi_wvalid,
  output reg                       s_axi_wready,
  output reg  [1:0]                s_axi_bresp,
  output reg                       s_axi_bvalid,
  input  wire                      s_axi_bready,
  input  wire [`HBCS_ADDR_W-1:0]   s_axi_araddr,
  input  wire                      s_axi_arvalid,
  output reg                       s_axi_arready,
  output reg  [31:0]               s_axi_rdata,
  output reg  [1:0]                s_axi_rresp,
  output reg                       s_axi_rvalid,
  input  wire                      s_axi_rready
);

  // ****************************************************************
  // Host pin synchronisers
  // ****************************************************************
  reg  [6:0]             pin_meta_r;
  reg  [6:0]             pin_sync_r;
  wire                   sel_n;
  wire                   wr_n;
  wire                   a17;
  wire                   a16;
  wire [2:0]             alo;

  // Two flip-flops per pin; only the second stage is read by logic.
  always @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      pin_meta_r <= 7'h7F;
      pin_sync_r <= 7'h7F;
    end
    else
    begin
      pin_meta_r <= {board_addressed_n_i, host_write_n_i, host_addr17_i, host_addr16_i, host_addr_lo_i};
      pin_sync_r <= pin_meta_r;
    end
  end

  assign sel_n = pin_sync_r[6];
  assign wr_n  = pin_sync_r[5];
  assign a17   = pin_sync_r[4];
  assign a16   = pin_sync_r[3];
  assign alo   = pin_sync_r[2:0];

  // ****************************************************************
  // Sequencer core
  // ****************************************************************
  reg  [`HBCS_AW-1:0]    pc_r;
  reg  [`HBCS_AW-1:0]    pc_nxt;
  reg                    cond_flag_r;
  reg                    restart_r;
  wire [`HBCS_IW-1:0]    instr;
  wire [`HBCS_CW-1:0]    cword;
  wire [2:0]             op;
  wire [`HBCS_AW-1:0]    tgt;
  wire [`HBCS_AW-1:0]    pc_inc;
  wire                   load_reset;

  assign cword      = instr[`HBCS_F_WORD_HI:`HBCS_F_WORD_LO];
  assign op         = instr[`HBCS_F_OP_HI:`HBCS_F_OP_LO];
  assign tgt        = instr[`HBCS_F_TGT_HI:`HBCS_F_TGT_LO];
  assign pc_inc     = pc_r + 6'h01;
  assign load_reset = !rst_b_i || restart_r;

  // Next address selection, one decision per cycle.
  always @*
  begin
    case (op)
      `HBCS_OP_CONT:    pc_nxt = pc_inc;
      `HBCS_OP_GOTO:    pc_nxt = (cond_flag_r == 1'b0) ? tgt : pc_inc;
      `HBCS_OP_MWCMD:   pc_nxt = (cond_flag_r == 1'b0) ? {sel_n, a17, a16, 3'h0} : pc_inc;
      `HBCS_OP_MWMOD:   pc_nxt = (cond_flag_r == 1'b0) ? {1'b0, a17, a16, alo} : pc_inc;
      `HBCS_OP_WAITSEL: pc_nxt = sel_n ? tgt : pc_r;
      `HBCS_OP_BRNWR:   pc_nxt = wr_n ? tgt : pc_inc;
      default:          pc_nxt = `HBCS_A_IDLE;
    endcase
  end

  // Program counter tracks the address of the word now in the store register.
  always @(posedge clk_i)
  begin
    if (load_reset)
    begin
      pc_r <= `HBCS_A_RESET;
    end
    else
    begin
      pc_r <= pc_nxt;
    end
  end

  // The condition flag is cleared by reset and nothing ever sets it.
  always @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      cond_flag_r <= 1'b0;
    end
  end

  // Microcode store; its register holds the instruction being executed.
  hbcs_ucode_rom u_rom
  (
    .clk_i        (clk_i),
    .load_reset_i (load_reset),
    .addr_i       (pc_nxt),
    .data_o       (instr)
  );

  // ****************************************************************
  // Control word outputs
  // ****************************************************************
  // Every output is a bit of the registered word, so all change together.
  assign ready_o                  = cword[`HBCS_B_READY];
  assign init_word_strobe_n_o     = cword[`HBCS_B_INIT_N];
  assign opmap_write_n_o          = cword[`HBCS_B_MAPWR_N];
  assign ctrl_store_shift_clk_o   = cword[`HBCS_B_CS_CLK];
  assign opcode_chain_shift_clk_o = cword[`HBCS_B_OC_CLK];
  assign diag_port_shift_clk_o    = cword[`HBCS_B_DP_CLK];
  assign shadow_mode_o            = cword[`HBCS_B_MODE];
  assign serial_in_select_o       = cword[`HBCS_B_SISEL];
  assign core_buffer_en_n_o       = cword[`HBCS_B_CORE_N];
  assign host_buffer_en_n_o       = cword[`HBCS_B_HOST_N];
  assign diag_readback_en_n_o     = cword[`HBCS_B_RDBK_N];
  assign memory_en_n_o            = cword[`HBCS_B_MEM_N];
  assign clock_command_o          = cword[3:0];

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  reg                    aw_held_r;
  reg                    w_held_r;
  reg [`HBCS_ADDR_W-1:0] aw_addr_r;
  reg [31:0]             w_data_r;
  reg [3:0]              w_strb_r;
  wire                   aw_take;
  wire                   w_take;
  wire                   aw_have;
  wire                   w_have;
  wire [`HBCS_ADDR_W-1:0] wr_addr;
  wire [31:0]            wr_data;
  wire [3:0]             wr_strb;
  wire                   wr_fire;

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take  = s_axi_wvalid && s_axi_wready;
  assign aw_have = aw_held_r || aw_take;
  assign w_have  = w_held_r || w_take;
  assign wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
  assign wr_data = w_held_r ? w_data_r : s_axi_wdata;
  assign wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;
  assign wr_fire = aw_have && w_have && !s_axi_bvalid;

  // Address and data are taken in either order and paired before the answer.
  always @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `HBCS_RESP_OKAY;
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      aw_addr_r     <= {`HBCS_ADDR_W{1'b0}};
      w_data_r      <= 32'h00000000;
      w_strb_r      <= 4'h0;
      restart_r     <= 1'b0;
    end
    else
    begin
      restart_r     <= 1'b0;
      s_axi_awready <= !aw_have && !s_axi_bvalid;
      s_axi_wready  <= !w_have && !s_axi_bvalid;
      if (aw_take)
      begin
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_take)
      begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held_r     <= 1'b0;
        w_held_r      <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b1;
        if (wr_addr == `HBCS_REG_CTRL)
        begin
          s_axi_bresp <= `HBCS_RESP_OKAY;
          restart_r   <= wr_strb[0] && wr_data[0];
        end
        else if (wr_addr == `HBCS_REG_STATUS || wr_addr == `HBCS_REG_CWORD)
        begin
          s_axi_bresp <= `HBCS_RESP_OKAY;
        end
        else
        begin
          s_axi_bresp <= `HBCS_RESP_SLVERR;
        end
      end
      else
      begin
        aw_held_r <= aw_have;
        w_held_r  <= w_have;
        if (s_axi_bvalid && s_axi_bready)
        begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  reg [31:0]             rd_word;
  reg [1:0]              rd_resp;

  // Read decode: status shows the program counter, word shows live outputs.
  always @*
  begin
    rd_word = 32'h00000000;
    rd_resp = `HBCS_RESP_OKAY;
    case (s_axi_araddr)
      `HBCS_REG_CTRL:   rd_word = 32'h00000000;
      `HBCS_REG_STATUS: rd_word = {24'h000000, cond_flag_r, sel_n, pc_r};
      `HBCS_REG_CWORD:  rd_word = {16'h0000, cword};
      default:          rd_resp = `HBCS_RESP_SLVERR;
    endcase
  end

  // One read at a time; the answer stands until the master takes it.
  always @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `HBCS_RESP_OKAY;
    end
    else if (s_axi_rvalid)
    begin
      s_axi_arready <= 1'b0;
      if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_resp;
    end
    else
    begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// ### hbcs_seq_chk.sv
// Purpose: Concurrent checks on the sequencer control word and host handshake.
// Assumes: Sees only the top module ports; one clock domain.
// Notes:   Pin timing includes the synchroniser.
module hbcs_seq_chk
(
  input wire       clk_i,
  input wire       rst_b_i,
  input wire       board_addressed_n_i,
  input wire       ready_o,
  input wire       init_word_strobe_n_o,
  input wire       opmap_write_n_o,
  input wire       ctrl_store_shift_clk_o,
  input wire       opcode_chain_shift_clk_o,
  input wire       diag_port_shift_clk_o,
  input wire       shadow_mode_o,
  input wire       serial_in_select_o,
  input wire       core_buffer_en_n_o,
  input wire       host_buffer_en_n_o,
  input wire       diag_readback_en_n_o,
  input wire       memory_en_n_o,
  input wire [3:0] clock_command_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // The whole control word, ready in the top bit.
  wire [15:0] cword = {ready_o, init_word_strobe_n_o, opmap_write_n_o, ctrl_store_shift_clk_o,
    opcode_chain_shift_clk_o, diag_port_shift_clk_o, shadow_mode_o, serial_in_select_o,
    core_buffer_en_n_o, host_buffer_en_n_o, diag_readback_en_n_o, memory_en_n_o, clock_command_o};

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // Word sequencing and per-word line checks.
  reset_word_a:
    assert property ($rose(rst_b_i) |-> cword == 16'h60F2 ##1 cword == 16'h6070)
    else $error("Bad reset sequence.");
  ready_sel_a:
    assert property (ready_o |-> !$past(board_addressed_n_i, 3))
    else $error("Ready without select.");
  ready_hold_a:
    assert property (ready_o && !$past(board_addressed_n_i, 2) |=> ready_o && $stable(cword))
    else $error("Answer word moved.");
  idle_return_a:
    assert property (ready_o && $past(board_addressed_n_i, 2) |=> cword == 16'h6070)
    else $error("No idle return.");
  mem_step_a:
    assert property (cword == 16'h60A1 |=> cword == 16'hE0A1)
    else $error("Bad memory step.");
  port_step_a:
    assert property (cword == 16'h62B1 |=> cword inside {16'hE6B1, 16'hE691})
    else $error("Bad port step.");
  ready_last_a:
    assert property ($rose(ready_o) |-> $past(cword) inside {16'h60A1, 16'h62B1, 16'h6070})
    else $error("Bad ready source.");
  code_range_a:
    assert property (ready_o || clock_command_o inside {4'h0, 4'h1, 4'h2})
    else $error("Bad idle clock code.");
  quiet_lines_a:
    assert property (init_word_strobe_n_o && opmap_write_n_o && !ctrl_store_shift_clk_o
      && !opcode_chain_shift_clk_o) else $error("Unused line active.");
  core_excl_a:
    assert property (!core_buffer_en_n_o |-> host_buffer_en_n_o && memory_en_n_o && diag_readback_en_n_o)
    else $error("Buffer clash.");
  dp_clk_a:
    assert property (diag_port_shift_clk_o |-> shadow_mode_o && !serial_in_select_o && ready_o)
    else $error("Bad port clock mode.");

  // Main scenarios reached.
  cover property (cword == 16'hE0A1);
  cover property (cword == 16'hE691);
  cover property (ready_o && $past(board_addressed_n_i, 2));
endmodule

bind hbcs_sequencer hbcs_seq_chk i_hbcs_seq_chk (.*);

// ### hbcs_host_model.sv
// Purpose: Behavioural host bus master that selects the board and waits.
// Assumes: Pins change by non-blocking assignment right after a rising edge.
// Notes:   Released address lines show the inverse of their last value.
module hbcs_host_model
(
  input  wire        clk_i,
  input  wire        ready_i,
  output logic       sel_n_o,
  output logic       write_n_o,
  output logic       addr17_o,
  output logic       addr16_o,
  output logic [2:0] addr_lo_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Deselected with address zero at start.
  initial
  begin
    sel_n_o = 1'b1;
    write_n_o = 1'b1;
    {addr17_o, addr16_o, addr_lo_o} = 5'h00;
  end

  // Select, wait for ready, hold, release.
  task automatic xfer(input logic [4:0] adr, input logic wr_n, input int hold,
                      output logic got, output int lat);
    lat = 0;
    got = 1'b0;
    sel_n_o <= 1'b0;
    write_n_o <= wr_n;
    {addr17_o, addr16_o, addr_lo_o} <= adr;
    while (!got && lat < 12)
    begin
      @(posedge clk_i);
      lat++;
      got = (ready_i === 1'b1);
    end
    repeat (hold) @(posedge clk_i);
    sel_n_o <= 1'b1;
    write_n_o <= ~wr_n;
    {addr17_o, addr16_o, addr_lo_o} <= ~adr;
    repeat (4) @(posedge clk_i);
  endtask
endmodule

// ### tb_host_bus_command_sequencer.sv
// Purpose: Self-checking bench for the host bus command sequencer.
// Assumes: Registers are reached over AXI4-Lite; one clock.
// Notes:   Every host address slot is tried, then random transfers follow.
module tb_host_bus_command_sequencer;
  timeunit 1ns;
  timeprecision 1ps;

  // Clock code per command slot, slot 15 down to 0; slots 0 and 8 never answer.
  localparam logic [63:0] CC_TAB = 64'h00001A9087654320;

  logic        clk_i;
  logic        rst_b_i;
  wire         sel_n, wr_n, a17, a16;
  wire  [2:0]  alo;
  wire  [15:0] cword;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, d;
  logic        awvalid, wvalid, bready, arvalid, rready, seen_rst;
  wire         awready, wready, bvalid, arready, rvalid;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  logic [1:0]  r;
  logic [15:0] last_w;
  logic [5:0]  k;
  int          error_cnt;
  int          n_tests;

  hbcs_sequencer i_hbcs_sequencer
  (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .board_addressed_n_i(sel_n), .host_write_n_i(wr_n),
    .host_addr17_i(a17), .host_addr16_i(a16), .host_addr_lo_i(alo),
    .ready_o(cword[15]), .init_word_strobe_n_o(cword[14]), .opmap_write_n_o(cword[13]),
    .ctrl_store_shift_clk_o(cword[12]), .opcode_chain_shift_clk_o(cword[11]),
    .diag_port_shift_clk_o(cword[10]), .shadow_mode_o(cword[9]), .serial_in_select_o(cword[8]),
    .core_buffer_en_n_o(cword[7]), .host_buffer_en_n_o(cword[6]), .diag_readback_en_n_o(cword[5]),
    .memory_en_n_o(cword[4]), .clock_command_o(cword[3:0]), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  hbcs_host_model u_host
  (
    .clk_i(clk_i), .ready_i(cword[15]), .sel_n_o(sel_n), .write_n_o(wr_n),
    .addr17_o(a17), .addr16_o(a16), .addr_lo_o(alo)
  );

  // ****************************************************************
  // Clock, capture and helpers
  // ****************************************************************
  // Free-running 100 MHz clock.
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Track last answer and restarts.
  always @(posedge clk_i)
  begin
    if (cword[15] === 1'b1)
      last_w <= cword;
    if (cword === 16'h60F2 && rst_b_i)
      seen_rst <= 1'b1;
  end

  // Compare one value and count it.
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
    n_tests++;
    if (sn !== ex)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, sn);
    end
  endtask

  // Expected {answers, word} for a host address and write strobe.
  function automatic logic [16:0] exp_word(input logic [4:0] a, input logic wn);
    if (a[4:3] == 2'b00)
      return {1'b1, 16'hE0A1};
    if (a[4:3] == 2'b01)
      return {1'b1, wn ? 16'hE691 : 16'hE6B1};
    return {a[2:0] != 3'h0, 12'hE07, CC_TAB[4*a[3:0] +: 4]};
  endfunction

  // Write one word; channels release independently.
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] dt, output logic [1:0] rs);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk_i);
    {awaddr, wdata, wstrb} <= {a, dt, 4'hF};
    {awvalid, wvalid, bready} <= 3'h7;
    while (!(aw_ok && w_ok))
    begin
      @(posedge clk_i);
      aw_ok |= (awready === 1'b1);
      w_ok |= (wready === 1'b1);
      awvalid <= !aw_ok;
      wvalid <= !w_ok;
    end
    do @(posedge clk_i); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask

  // Read one word.
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] dt, output logic [1:0] rs);
    @(posedge clk_i);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do @(posedge clk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_i); while (rvalid !== 1'b1);
    dt = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  // One host transfer with its checks.
  task automatic run_xfer(input logic [4:0] adr, input logic wn, input int hold);
    logic [16:0] ex;
    logic        rdy;
    int          lat;
    ex = exp_word(adr, wn);
    u_host.xfer(adr, wn, hold, rdy, lat);
    chk("ready", ex[16], rdy);
    if (ex[16])
    begin
      chk("word", ex[15:0], last_w);
      chk("latency", 32'h5, lat);
    end
    chk("idle", 16'h6070, cword);
  endtask

  // Print counts and the verdict, then stop.
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  // Reset, registers, every slot, random transfers.
  initial
  begin
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready, seen_rst} = '0;
    error_cnt = 0;
    n_tests = 0;
    rst_b_i = 1'b0;
    void'($urandom(32'hC641));
    repeat (8) @(posedge clk_i);
    chk("reset word", 16'h60F2, cword);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    seen_rst = 1'b0;
    chk("idle word", 16'h6070, cword);
    axi_rd(4'h4, d, r);
    chk("status", 32'h60, d);
    axi_rd(4'h8, d, r);
    chk("cword reg", 32'h6070, d);
    axi_rd(4'hC, d, r);
    chk("bad read resp", 2'h2, r);
    chk("bad read data", 32'h0, d);
    axi_wr(4'hC, 32'h1, r);
    chk("bad write resp", 2'h2, r);
    axi_wr(4'h0, 32'h1, r);
    chk("ctrl resp", 2'h0, r);
    repeat (3) @(posedge clk_i);
    chk("restart seen", 1'b1, seen_rst);
    axi_rd(4'h0, d, r);
    chk("ctrl clears", 32'h0, d);
    for (int i = 0; i < 104; i++)
    begin
      k = (i < 64) ? i[5:0] : 6'($urandom);
      run_xfer(k[4:0], k[5], (i < 64) ? 0 : $urandom_range(3, 0));
    end
    tally_and_finish();
  end

  // Cut a hang short.
  initial
  begin
    repeat (6000) @(posedge clk_i);
    error_cnt++;
    tally_and_finish();
  end
endmodule
